// File: hdl/imr_pkg.sv
// Function
// [RQ1] control bits choose tri-state or push-pull pins
// [RQ2] sources sharing a pin are ORed
// [RQ3] lock bit selects synchronous-sample mapping
// [RQ4] lock mode: handshake goes to pin a
// [RQ5] lock mode: enabled motion events to pin a
// [RQ6] lock mode: no buffer, sample pulse pin b
// [RQ7] free mode: status bits mirror pin levels
// [RQ8] free mode: handshake on pin a or polled
// [RQ9] free mode: motion routing bit picks pin
// [RQ10] five bits enable motion engines individually
// [RQ11] bypass enables sample pulse, else buffer
// [RQ12] buffer interrupt pin chosen by bit two
// [RQ13] block bit gates sample pulse to pin b
// [RQ14] data updates while low, then timed pulse
// [RQ15] pulse width depends on rate and sensors
// [RQ16] host reads data while pin b high
// [RQ17] reset gives default mode, sensors off
// [RQ18] rate 11xx, sensors off: slow clock idle
// [RQ19] power-down request stops blocks, keeps registers; the code acts on it only with both sensors off
// [RQ20] accel only: normal or low-power by rate
// [RQ21] snooze keeps gyro drive, no gyro data
// [RQ22] both enabled: snooze gives accel data only
// [RQ23] command done set, cleared by acknowledge write
package imr_pkg;
  // register byte addresses
  localparam logic [7:0] pin_and_power_control_reg_addr = 8'h00;
  localparam logic [7:0] accel_rate_control_reg_addr    = 8'h04;
  localparam logic [7:0] sensor_enable_control_reg_addr = 8'h08;
  localparam logic [7:0] event_routing_control_reg_addr = 8'h0c;
  localparam logic [7:0] host_command_reg_addr          = 8'h10;
  localparam logic [7:0] irq_status_reg_addr            = 8'h14;
  localparam logic [7:0] buffer_mode_reg_addr           = 8'h18;
  localparam logic [7:0] op_mode_reg_addr               = 8'h1c;
  // field positions
  localparam int power_down_request_bit = 0;
  localparam int buf_irq_pin_a_bit      = 2;
  localparam int pin_a_drive_bit        = 3;
  localparam int pin_b_drive_bit        = 4;
  localparam int accel_enable_bit       = 0;
  localparam int gyro_enable_bit        = 1;
  localparam int gyro_snooze_bit        = 4;
  localparam int new_sample_pulse_block_bit = 5;
  localparam int lock_enable_bit        = 7;
  localparam int motion_to_pin_a_bit    = 6;
  localparam int handshake_poll_bit     = 7;
  localparam int command_finished_bit   = 7;
  localparam int status_pin_a_bit       = 1;
  localparam int status_pin_b_bit       = 0;
  localparam int motion_engines         = 5;
  // reset values and codes
  localparam logic [7:0] ctrl_reset_value = 8'h00;
  localparam logic [7:0] command_ack_code = 8'h00;
  localparam logic [1:0] buffer_bypass    = 2'h0;
  localparam logic [1:0] rate_low_power   = 2'h3;
  // pulse timing
  localparam int clock_hz       = 50_000_000;
  localparam int pulse_ns_short = 100;
  localparam int pulse_ns_long  = 200;
  localparam int pulse_cycles_short = (pulse_ns_short * (clock_hz / 1_000_000) + 999) / 1000;
  localparam int pulse_cycles_long  = (pulse_ns_long * (clock_hz / 1_000_000) + 999) / 1000;

  // operating modes
  typedef enum logic [3:0]
  {
    imr_mode_default    = 4'h0,
    imr_mode_low_power  = 4'h1,
    imr_mode_power_down = 4'h2,
    imr_mode_accel      = 4'h3,
    imr_mode_accel_lp   = 4'h4,
    imr_mode_gyro_snz   = 4'h5,
    imr_mode_gyro       = 4'h6,
    imr_mode_imu        = 4'h7,
    imr_mode_accel_snz  = 4'h8
  } imr_mode_t;

  // event sources
  typedef struct packed
  {
    logic       cmd_done;
    logic [4:0] motion;
    logic       buf_irq;
    logic       sample_tick;
  } imr_src_t;
endpackage

// File: hdl/imr_pulse.sv
`timescale 1ns/100ps
// data-ready pulse generator with selectable width
module imr_pulse
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // control
  input  wire logic       tick,
  input  wire logic       long_width,
  // output
  output logic            pulse
);
  typedef struct packed
  {
    logic       high;
    logic [7:0] count;
  } imr_pulse_state_t;

  imr_pulse_state_t state;
  imr_pulse_state_t next_state;

  // start on tick, clear when count expires
  always_comb
  begin
    next_state = state;
    if (tick && !state.high)
    begin
      next_state.high  = 1'b1;
      next_state.count = long_width ? 8'(imr_pkg::pulse_cycles_long) : 8'(imr_pkg::pulse_cycles_short); // RQ15
    end
    else if (state.high)
    begin
      if (state.count <= 8'h01)
      begin
        next_state.high  = 1'b0; // RQ14
        next_state.count = 8'h00;
      end
      else
      begin
        next_state.count = state.count - 8'h01;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state <= '0;
    else
      state <= next_state;
  end

  assign pulse = state.high;

  pulse_width_a: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(pulse) && !$past(long_width) |-> pulse [*5] ##1 !pulse) // RQ15
    else $error("short pulse width wrong");
endmodule

// File: hdl/imr_router.sv
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
// interrupt router with axi4-lite register slave
module imr_router
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // internal sources
  input  wire logic        cmd_complete,
  input  wire logic [4:0]  motion_event,
  input  wire logic        buffer_irq,
  input  wire logic        sample_tick,
  // pins
  output logic             irq_pin_a_o,
  output logic             irq_pin_a_oe,
  output logic             irq_pin_b_o,
  output logic             irq_pin_b_oe,
  // operating state
  output logic [4:0]       motion_engine_enable,
  output logic             buffer_enable,
  output logic             slow_clock_select,
  output logic             blocks_powered,
  output logic             accel_data_on,
  output logic             gyro_drive_on,
  output logic             gyro_data_on,
  output logic             data_update,
  output imr_pkg::imr_mode_t op_mode
);
  typedef struct packed
  {
    logic [7:0]         pin_and_power_control_reg;
    logic [7:0]         accel_rate_control_reg;
    logic [7:0]         sensor_enable_control_reg;
    logic [7:0]         event_routing_control_reg;
    logic [7:0]         host_command_reg;
    logic [1:0]         buffer_mode;
    logic               command_finished_flag;
    logic               aw_held;
    logic [7:0]         aw_addr;
    logic               w_held;
    logic [31:0]        w_data;
    logic [3:0]         w_strb;
    logic               bvalid;
    logic [1:0]         bresp;
    logic               rvalid;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               pin_a;
    logic               pin_b;
    logic               data_update;
    imr_pkg::imr_mode_t mode;
  } imr_state_t;

  imr_state_t state;
  imr_state_t next_state;
  logic       new_sample_pulse;
  logic       lock_sampling_mode;
  logic       sample_path_on;
  logic       wr_fire;
  logic       ack_write;
  logic       pin_a_level;
  logic       pin_b_level;
  logic [31:0] status_word;
  logic        wide_pulse;
  logic [3:0]  rate_hi;

  // mode decode from control registers
  assign lock_sampling_mode = state.sensor_enable_control_reg[imr_pkg::lock_enable_bit]; // RQ3
  assign sample_path_on = lock_sampling_mode || (state.buffer_mode == imr_pkg::buffer_bypass); // RQ6 RQ11
  assign buffer_enable = !lock_sampling_mode && (state.buffer_mode != imr_pkg::buffer_bypass); // RQ6 RQ11
  assign motion_engine_enable = state.event_routing_control_reg[imr_pkg::motion_engines-1:0]; // RQ10
  assign rate_hi = state.accel_rate_control_reg[3:0];
  assign wide_pulse = state.sensor_enable_control_reg[imr_pkg::accel_enable_bit]
                    && state.sensor_enable_control_reg[imr_pkg::gyro_enable_bit] || rate_hi[3];

  // data-ready pulse with width chosen from rate and sensors
  imr_pulse u_pulse
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .tick       (sample_tick && (accel_data_on || gyro_data_on)),
    .long_width (wide_pulse), // RQ15
    .pulse      (new_sample_pulse)
  );

  // pin levels, sources ORed per pin
  always_comb
  begin
    logic [4:0] mot;
    mot = motion_event & motion_engine_enable;
    pin_a_level = 1'b0;
    pin_b_level = 1'b0;
    if (lock_sampling_mode)
    begin
      pin_a_level = state.command_finished_flag | (|mot); // RQ2 RQ4 RQ5
      pin_b_level = new_sample_pulse; // RQ6
    end
    else
    begin
      if (!state.event_routing_control_reg[imr_pkg::handshake_poll_bit])
        pin_a_level = state.command_finished_flag; // RQ8
      if (state.event_routing_control_reg[imr_pkg::motion_to_pin_a_bit])
        pin_a_level = pin_a_level | (|mot); // RQ9 RQ2
      else
        pin_b_level = pin_b_level | (|mot); // RQ9
      if (buffer_enable)
      begin
        if (state.pin_and_power_control_reg[imr_pkg::buf_irq_pin_a_bit])
          pin_a_level = pin_a_level | buffer_irq; // RQ12
        else
          pin_b_level = pin_b_level | buffer_irq; // RQ12
      end
      else if (!state.sensor_enable_control_reg[imr_pkg::new_sample_pulse_block_bit])
        pin_b_level = pin_b_level | new_sample_pulse; // RQ13
    end
  end

  // pin drivers; push-pull when bit set, else released
  assign irq_pin_a_o  = state.pin_a;
  assign irq_pin_b_o  = state.pin_b;
  assign irq_pin_a_oe = state.pin_and_power_control_reg[imr_pkg::pin_a_drive_bit]; // RQ1
  assign irq_pin_b_oe = state.pin_and_power_control_reg[imr_pkg::pin_b_drive_bit]; // RQ1

  // sensor power outputs
  always_comb
  begin
    logic accel_enable;
    logic gen;
    logic snz;
    accel_enable = state.sensor_enable_control_reg[imr_pkg::accel_enable_bit];
    gen = state.sensor_enable_control_reg[imr_pkg::gyro_enable_bit];
    snz = state.sensor_enable_control_reg[imr_pkg::gyro_snooze_bit];
    slow_clock_select = !accel_enable && !gen && (rate_hi[3:2] == imr_pkg::rate_low_power); // RQ18
    blocks_powered = !(!accel_enable && !gen && state.pin_and_power_control_reg[imr_pkg::power_down_request_bit]); // RQ19
    accel_data_on = accel_enable; // RQ20 RQ22
    gyro_drive_on = gen; // RQ21
    gyro_data_on  = gen && !snz; // RQ21 RQ22
  end

  assign data_update = state.data_update;
  assign op_mode     = state.mode;

  // mirror word for the status register
  always_comb
  begin
    status_word = 32'h0;
    status_word[imr_pkg::command_finished_bit] = state.command_finished_flag;
    if (!lock_sampling_mode)
    begin
      status_word[imr_pkg::status_pin_a_bit] = state.pin_a; // RQ7
      status_word[imr_pkg::status_pin_b_bit] = state.pin_b; // RQ7
    end
  end

  assign wr_fire   = state.aw_held && state.w_held && !state.bvalid;
  assign ack_write = wr_fire && state.aw_addr == imr_pkg::host_command_reg_addr && state.w_strb[0]
                   && state.w_data[7:0] == imr_pkg::command_ack_code;

  // bus handshakes
  assign s_axi_awready = !state.aw_held;
  assign s_axi_wready  = !state.w_held;
  assign s_axi_arready = !state.rvalid;
  assign s_axi_bvalid  = state.bvalid;
  assign s_axi_bresp   = state.bresp;
  assign s_axi_rvalid  = state.rvalid;
  assign s_axi_rdata   = state.rdata;
  assign s_axi_rresp   = state.rresp;

  // next state: bus slave, registers, flags, pins, mode
  always_comb
  begin
    logic accel_enable;
    logic gen;
    logic snz;
    logic odr_lp;
    accel_enable = state.sensor_enable_control_reg[imr_pkg::accel_enable_bit];
    gen = state.sensor_enable_control_reg[imr_pkg::gyro_enable_bit];
    snz = state.sensor_enable_control_reg[imr_pkg::gyro_snooze_bit];
    odr_lp = (rate_hi[3:2] == imr_pkg::rate_low_power);
    next_state = state;
    next_state.pin_a = pin_a_level;
    next_state.pin_b = pin_b_level;
    next_state.data_update = sample_tick && !new_sample_pulse; // RQ14
    if (s_axi_awvalid && !state.aw_held)
    begin
      next_state.aw_held = 1'b1;
      next_state.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state.w_held)
    begin
      next_state.w_held = 1'b1;
      next_state.w_data = s_axi_wdata;
      next_state.w_strb = s_axi_wstrb;
    end
    if (wr_fire)
    begin
      next_state.aw_held = 1'b0;
      next_state.w_held  = 1'b0;
      next_state.bvalid  = 1'b1;
      next_state.bresp   = 2'b00;
      if (state.w_strb[0])
      begin
        unique case (state.aw_addr)
          imr_pkg::pin_and_power_control_reg_addr: next_state.pin_and_power_control_reg = state.w_data[7:0];
          imr_pkg::accel_rate_control_reg_addr:    next_state.accel_rate_control_reg = state.w_data[7:0];
          imr_pkg::sensor_enable_control_reg_addr: next_state.sensor_enable_control_reg = state.w_data[7:0];
          imr_pkg::event_routing_control_reg_addr: next_state.event_routing_control_reg = state.w_data[7:0];
          imr_pkg::host_command_reg_addr:          next_state.host_command_reg = state.w_data[7:0];
          imr_pkg::buffer_mode_reg_addr:           next_state.buffer_mode = state.w_data[1:0];
          imr_pkg::irq_status_reg_addr, imr_pkg::op_mode_reg_addr: ;
          default: next_state.bresp = 2'b10;
        endcase
      end
    end
    if (state.bvalid && s_axi_bready)
      next_state.bvalid = 1'b0;
    if (s_axi_arvalid && !state.rvalid)
    begin
      next_state.rvalid = 1'b1;
      next_state.rresp  = 2'b00;
      unique case (s_axi_araddr)
        imr_pkg::pin_and_power_control_reg_addr: next_state.rdata = {24'h0, state.pin_and_power_control_reg};
        imr_pkg::accel_rate_control_reg_addr:    next_state.rdata = {24'h0, state.accel_rate_control_reg};
        imr_pkg::sensor_enable_control_reg_addr: next_state.rdata = {24'h0, state.sensor_enable_control_reg};
        imr_pkg::event_routing_control_reg_addr: next_state.rdata = {24'h0, state.event_routing_control_reg};
        imr_pkg::host_command_reg_addr:          next_state.rdata = {24'h0, state.host_command_reg};
        imr_pkg::irq_status_reg_addr:            next_state.rdata = status_word;
        imr_pkg::buffer_mode_reg_addr:           next_state.rdata = {30'h0, state.buffer_mode};
        imr_pkg::op_mode_reg_addr:               next_state.rdata = {28'h0, state.mode};
        default:
        begin
          next_state.rdata = 32'h0;
          next_state.rresp = 2'b10;
        end
      endcase
    end
    if (state.rvalid && s_axi_rready)
      next_state.rvalid = 1'b0;
    // completion wins over a same-cycle acknowledge
    if (ack_write)
      next_state.command_finished_flag = 1'b0; // RQ23
    if (cmd_complete)
      next_state.command_finished_flag = 1'b1; // RQ23
    // operating mode decode
    if (!accel_enable && !gen)
    begin
      if (state.pin_and_power_control_reg[imr_pkg::power_down_request_bit])
        next_state.mode = imr_pkg::imr_mode_power_down; // RQ19
      else if (odr_lp)
        next_state.mode = imr_pkg::imr_mode_low_power; // RQ18
      else
        next_state.mode = imr_pkg::imr_mode_default; // RQ17
    end
    else if (accel_enable && !gen)
      next_state.mode = odr_lp ? imr_pkg::imr_mode_accel_lp : imr_pkg::imr_mode_accel; // RQ20
    else if (!accel_enable)
      next_state.mode = snz ? imr_pkg::imr_mode_gyro_snz : imr_pkg::imr_mode_gyro; // RQ21
    else
      next_state.mode = snz ? imr_pkg::imr_mode_accel_snz : imr_pkg::imr_mode_imu; // RQ22
  end

  // state register, default mode at reset
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state <= '0; // RQ17
      state.mode <= imr_pkg::imr_mode_default;
    end
    else
      state <= next_state;
  end

  lock_pin_a_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_sampling_mode && state.command_finished_flag |=> irq_pin_a_o || !$past(lock_sampling_mode)) // RQ4
    else $error("handshake missing on pin a");
  lock_pin_b_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lock_sampling_mode && $past(lock_sampling_mode) |-> irq_pin_b_o == $past(new_sample_pulse)) // RQ6
    else $error("pin b not sample pulse");
  status_mirror_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_arvalid && !state.rvalid && s_axi_araddr == imr_pkg::irq_status_reg_addr && !lock_sampling_mode
    |=> s_axi_rdata[1:0] == $past({irq_pin_a_o, irq_pin_b_o})) // RQ7
    else $error("status mirror wrong");
  drive_mode_a: assert property (@(posedge aclk) disable iff (!aresetn)
    irq_pin_a_oe == state.pin_and_power_control_reg[3] && irq_pin_b_oe == state.pin_and_power_control_reg[4]) // RQ1
    else $error("drive mode wrong");
  done_set_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_complete |=> state.command_finished_flag) // RQ23
    else $error("done flag not set");
  done_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ack_write && !cmd_complete |=> !state.command_finished_flag) // RQ23
    else $error("done flag not cleared");
  buffer_sel_a: assert property (@(posedge aclk) disable iff (!aresetn)
    buffer_enable |-> !lock_sampling_mode && state.buffer_mode != 2'h0) // RQ11
    else $error("buffer enable wrong");
  snooze_data_a: assert property (@(posedge aclk) disable iff (!aresetn)
    gyro_drive_on && state.sensor_enable_control_reg[4] |-> !gyro_data_on) // RQ21
    else $error("gyro data in snooze");
  power_down_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !blocks_powered |-> !accel_data_on && !gyro_drive_on ##1 op_mode == imr_pkg::imr_mode_power_down) // RQ19
    else $error("power down with sensors");
endmodule

// File: test/imr_host_pins.sv
`timescale 1ns/100ps
// host side view of the two interrupt wires
module imr_host_pins
(
  // clock
  input  wire logic aclk,
  // pins from the device
  input  wire logic irq_pin_a_o,
  input  wire logic irq_pin_a_oe,
  input  wire logic irq_pin_b_o,
  input  wire logic irq_pin_b_oe,
  // wire levels seen by the host
  output logic      pin_a,
  output logic      pin_b
);
  logic last_a;
  logic last_b;

  // remember the last driven level
  always_ff @(posedge aclk)
  begin
    if (irq_pin_a_oe)
      last_a <= irq_pin_a_o;
    if (irq_pin_b_oe)
      last_b <= irq_pin_b_o;
  end

  // no pull on the wires: a released pin shows the inverse of its last level
  assign pin_a = irq_pin_a_oe ? irq_pin_a_o : ~last_a;
  assign pin_b = irq_pin_b_oe ? irq_pin_b_o : ~last_b;
endmodule

// File: test/testbench.sv
`timescale 1ns/100ps
// register and pin level test of the interrupt router
module testbench;
  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        cmd, buf_irq, tick;
  logic [4:0]  motion, eng_en;
  logic        a_o, a_oe, b_o, b_oe, pin_a, pin_b;
  logic        buf_en, slow, powered, a_data, g_drive, g_data, upd_o;
  imr_pkg::imr_mode_t mode;
  logic [31:0] d;
  logic [1:0]  r, b;
  int          w, n_errors, checks_done;
  logic        upd;
  logic [7:0]  m_c0 [9] = '{8'h18, 8'h18, 8'h19, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18, 8'h18};
  logic [7:0]  m_rt [9] = '{8'h00, 8'h0c, 8'h00, 8'h00, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00};
  logic [7:0]  m_se [9] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h12, 8'h02, 8'h03, 8'h13};
  logic [3:0]  m_on [9] = '{4'h8, 4'h8, 4'h0, 4'h9, 4'h9, 4'hc, 4'he, 4'hf, 4'hd};

  imr_router dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cmd_complete(cmd),
    .motion_event(motion), .buffer_irq(buf_irq), .sample_tick(tick), .irq_pin_a_o(a_o),
    .irq_pin_a_oe(a_oe), .irq_pin_b_o(b_o), .irq_pin_b_oe(b_oe), .motion_engine_enable(eng_en),
    .buffer_enable(buf_en), .slow_clock_select(slow), .blocks_powered(powered), .accel_data_on(a_data),
    .gyro_drive_on(g_drive), .gyro_data_on(g_data), .data_update(upd_o), .op_mode(mode));
  imr_host_pins host (.aclk(aclk), .irq_pin_a_o(a_o), .irq_pin_a_oe(a_oe), .irq_pin_b_o(b_o),
    .irq_pin_b_oe(b_oe), .pin_a(pin_a), .pin_b(pin_b));

  // 50 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // verdict and end of run
  task automatic report_and_stop;
    $display("Checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // bounded wait step
  task automatic bound(inout int n);
    n++;
    if (n > 100)
    begin
      n_errors++;
      $display("Error bus wait timed out");
      report_and_stop;
    end
  endtask

  // one comparison
  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // write: address and data offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    logic aw_left, w_left, aw_hit, w_hit, b_hit;
    n = 0;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (aw_left || w_left)
    begin
      @(negedge aclk);
      aw_hit = aw_left && awready;
      w_hit = w_left && wready;
      @(posedge aclk);
      if (aw_hit)
        awvalid <= 1'b0;
      if (w_hit)
        wvalid <= 1'b0;
      aw_left = aw_left && !aw_hit;
      w_left = w_left && !w_hit;
      bound(n);
    end
    do
    begin
      @(negedge aclk);
      b_hit = bvalid;
      b = bresp;
      @(posedge aclk);
      bound(n);
    end while (!b_hit);
    bready <= 1'b0;
  endtask

  // read: data and response taken at the edge with rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] s);
    int n;
    logic ar_hit, r_hit;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(negedge aclk);
      ar_hit = arready;
      @(posedge aclk);
      bound(n);
    end while (!ar_hit);
    arvalid <= 1'b0;
    do
    begin
      @(negedge aclk);
      r_hit = rvalid;
      v = rdata;
      s = rresp;
      @(posedge aclk);
      bound(n);
    end while (!r_hit);
    rready <= 1'b0;
  endtask

  // let register and pin stages land
  task automatic settle;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask

  // one command completion pulse
  task automatic cmd_pulse;
    @(posedge aclk);
    cmd <= 1'b1;
    @(posedge aclk);
    cmd <= 1'b0;
    settle;
  endtask

  // one sample tick, then count high cycles of pin b
  task automatic tick_width;
    w = 0;
    upd = 1'b0;
    @(posedge aclk);
    tick <= 1'b1;
    @(posedge aclk);
    tick <= 1'b0;
    repeat (30)
    begin
      @(negedge aclk);
      if (upd_o === 1'b1 && pin_b === 1'b0)
        upd = 1'b1;
      if (upd_o === 1'b1 && pin_b === 1'b1)
        upd = 1'b0;
      if (pin_b === 1'b1)
        w++;
    end
  endtask

  // main sequence
  initial
  begin
    {aresetn, awaddr, araddr, awvalid, wvalid, bready, arvalid, rready, wdata} = '0;
    {cmd, buf_irq, tick, motion} = '0;
    wstrb = 4'hf;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    // reset state and pin drive
    rd(imr_pkg::pin_and_power_control_reg_addr, d, r);
    check("ctrl reset", 32'h0, d);
    check("mode reset", 32'h0, 32'(mode));
    check("oe reset", 32'h0, 32'({a_oe, b_oe}));
    wr(imr_pkg::pin_and_power_control_reg_addr, 32'h18);
    settle;
    check("oe push pull", 32'h3, 32'({a_oe, b_oe}));
    check("bresp okay", 32'h0, 32'(b));
    rd(8'h3c, d, r);
    check("unmapped rresp", 32'h2, 32'(r));
    wr(8'h3c, 32'h0);
    check("unmapped bresp", 32'h2, 32'(b));
    // free mapping: engine enables, motion routing, status mirror
    wr(imr_pkg::event_routing_control_reg_addr, 32'h5e);
    check("engines", 32'h1e, 32'(eng_en));
    motion <= 5'h01;
    settle;
    check("disabled engine", 32'h0, 32'({pin_a, pin_b}));
    motion <= 5'h06;
    settle;
    check("motion to a", 32'h2, 32'({pin_a, pin_b}));
    rd(imr_pkg::irq_status_reg_addr, d, r);
    check("status mirror a", 32'h2, 32'(d[1:0]));
    wr(imr_pkg::event_routing_control_reg_addr, 32'h1e);
    settle;
    check("motion to b", 32'h1, 32'({pin_a, pin_b}));
    rd(imr_pkg::irq_status_reg_addr, d, r);
    check("status mirror b", 32'h1, 32'(d[1:0]));
    motion <= 5'h00;
    // handshake on pin a, then polled; host acknowledges each
    for (int p = 0; p < 2; p++)
    begin
      wr(imr_pkg::event_routing_control_reg_addr, p ? 32'h9e : 32'h1e);
      cmd_pulse;
      check("handshake pin a", 32'(p == 0), 32'(pin_a));
      rd(imr_pkg::irq_status_reg_addr, d, r);
      check("done set", 32'h1, 32'(d[7]));
      wr(imr_pkg::host_command_reg_addr, 32'(imr_pkg::command_ack_code));
      settle;
      rd(imr_pkg::irq_status_reg_addr, d, r);
      check("done cleared", 32'h0, 32'({d[7], pin_a}));
    end
    // buffer interrupt pin select, pin a then pin b, motion inputs idle
    wr(imr_pkg::buffer_mode_reg_addr, 32'h1);
    check("buffer on", 32'h1, 32'(buf_en));
    buf_irq <= 1'b1;
    wr(imr_pkg::pin_and_power_control_reg_addr, 32'h1c);
    settle;
    check("buffer to a", 32'h2, 32'({pin_a, pin_b}));
    wr(imr_pkg::pin_and_power_control_reg_addr, 32'h18);
    settle;
    check("buffer to b", 32'h1, 32'({pin_a, pin_b}));
    buf_irq <= 1'b0;
    // data-ready: disabled by buffer, width by sensors, gated by block bit
    wr(imr_pkg::sensor_enable_control_reg_addr, 32'h01);
    tick_width;
    check("pulse off in buffer mode", 32'h0, 32'(w));
    wr(imr_pkg::buffer_mode_reg_addr, 32'(imr_pkg::buffer_bypass));
    check("buffer off", 32'h0, 32'(buf_en));
    tick_width;
    check("short pulse", 32'(imr_pkg::pulse_cycles_short), 32'(w));
    check("update while low", 32'h1, 32'(upd));
    wr(imr_pkg::sensor_enable_control_reg_addr, 32'h03);
    tick_width;
    check("long pulse", 32'(imr_pkg::pulse_cycles_long), 32'(w));
    wr(imr_pkg::sensor_enable_control_reg_addr, 32'h21);
    tick_width;
    check("pulse blocked", 32'h0, 32'(w));
    // lock mapping: motion and handshake to a, data-ready to b, no buffer
    wr(imr_pkg::sensor_enable_control_reg_addr, 32'h81);
    wr(imr_pkg::buffer_mode_reg_addr, 32'h1);
    check("no buffer in lock", 32'h0, 32'(buf_en));
    motion <= 5'h04;
    settle;
    check("lock motion to a", 32'h2, 32'({pin_a, pin_b}));
    motion <= 5'h00;
    cmd_pulse;
    check("lock handshake a", 32'h2, 32'({pin_a, pin_b}));
    wr(imr_pkg::host_command_reg_addr, 32'(imr_pkg::command_ack_code));
    tick_width;
    check("lock pulse on b", 32'(imr_pkg::pulse_cycles_short), 32'(w));
    // operating modes from control bits
    for (int i = 0; i < 9; i++)
    begin
      wr(imr_pkg::pin_and_power_control_reg_addr, 32'(m_c0[i]));
      wr(imr_pkg::accel_rate_control_reg_addr, 32'(m_rt[i]));
      wr(imr_pkg::sensor_enable_control_reg_addr, 32'(m_se[i]));
      settle;
      check("op mode", 32'(i), 32'(mode));
      check("power and data", 32'(m_on[i]), 32'({powered, g_drive, g_data, a_data}));
      if (i < 2)
        check("slow clock", 32'(i), 32'(slow));
      rd(imr_pkg::accel_rate_control_reg_addr, d, r);
      check("config kept", 32'(m_rt[i]), d);
    end
    report_and_stop;
  end
endmodule
